// ### src/ism_defines.svh
`ifndef ISM_DEFINES_SVH
`define ISM_DEFINES_SVH
// ************************************
// register byte offsets
// ************************************
`define ISM_A_DATA    8'h00
`define ISM_A_CTRL    8'h04
`define ISM_A_STAT    8'h08
`define ISM_A_RATE    8'h0C
// ************************************
// sequence_control_register fields
// ************************************
`define ISM_C_SEN     0
`define ISM_C_PEN     2
`define ISM_C_RECEIVE_SEQUENCE_ENABLE    3
`define ISM_C_ACK_SEQUENCE_ENABLE   4
`define ISM_C_ACK_VALUE_BIT   5
`define ISM_C_ACKST   6
`define ISM_C_EN      7
`define ISM_C_IE      8
// ************************************
// port_status_register fields
// ************************************
`define ISM_S_BF      0
`define ISM_S_WRITE_COLLISION_FLAG    1
`define ISM_S_OV      2
`define ISM_S_START   3
`define ISM_S_STOP    4
`define ISM_S_PE      5
`define ISM_S_BCL     6
`define ISM_S_IDLE    7
// ************************************
// reset values and bit counts
// ************************************
`define ISM_RATE_RST  7'h09
`define ISM_LAST_BIT  4'h7
`define ISM_ACK_BIT   4'h8
`define ISM_BIT_FIRST 4'h0
`endif

// ### src/ism_pkg.sv
`default_nettype none
package ism_pkg;
  // one-hot sequencer states
  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_ST1  = 8'h02,
    S_ST2  = 8'h04,
    S_LOW  = 8'h08,
    S_HIGH = 8'h10,
    S_SP1  = 8'h20,
    S_SP2  = 8'h40,
    S_SP3  = 8'h80
  } ism_state_t;
  // byte-level operation in the clocked phases
  typedef enum logic [2:0] {
    OP_TX  = 3'h1,
    OP_RX  = 3'h2,
    OP_ACK = 3'h4
  } ism_op_t;
endpackage
`default_nettype wire

// ### src/ism_master.sv
// Functional notes
// - buffer write sets buffer_full_flag; cleared after eighth bit shifted out.
// - buffer write during any sequence is ignored and sets write_collision_flag.
// - slave acknowledge 0 clears ack_status_bit, 1 sets it.
// - receive enable accepted only while idle, otherwise disregarded.
// - reception toggles clock per counter timeout, shifts data each clock.
// - after eighth receive clock load buffer, set flags, hold clock low, idle.
// - reception sets buffer_full_flag on load; buffer read clears it.
// - byte completing while buffer still full sets receive_overflow_flag.
// - ack sequence pulls clock low and drives ack_value_bit on data.
// - ack waits a period, releases clock, waits high period, pulls low, idles.
// - stop drives data low, counts, releases clock, later releases data.
// - data high with clock high sets stop-seen; period later stop completes.
// - released clock suspends counter until sampled high, then reloads.
// - reset or port disable ends transfers and clears start/stop seen.
// - bus taken whenever idle; start/stop seen are not checked; stop raises interrupt.
// - released data sampled low during clock high is a collision, except in reception and the transmit ack bit.
// - transmit collision halts, clears buffer full, releases both lines.
// - sequence collision aborts, releases lines, clears its enable bit.
// - after collision monitor stops; new write restarts from first bit.
// - either line low at start begin aborts start with collision.
// - start counts once data high; clock low meanwhile is a collision.
// - data low early asserts start early; else assert at timeout.
// - counter reloads from low seven bits, counts to zero, stops.
// - counter decrements on each internal phase clock.
// - transmitter releases data after eighth clock, samples ack at ninth.
`timescale 1ns/1ns
`default_nettype none
`include "ism_defines.svh"
module ism_master (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             scl_o,
  output logic             scl_oe,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             port_irq,
  output logic             coll_irq
);
  import ism_pkg::*;

  // ************************************
  // state
  // ************************************
  ism_state_t  st_ff, nxt_st;
  ism_op_t     op_ff, nxt_op;
  logic [6:0]  rate_ff, cnt_ff, nxt_cnt;
  logic [7:0]  buf_ff, sr_ff, nxt_sr;
  logic [3:0]  bit_ff, nxt_bit;
  logic        hi_ff, nxt_hi, scl_oe_ff, nxt_scl, sda_oe_ff, nxt_sda;
  logic        sen_ff, pen_ff, receive_sequence_enable_ff, ack_sequence_enable_ff, ack_value_bit_ff, ackst_ff;
  logic        en_ff, ie_ff, bf_ff, write_collision_flag_ff, ov_ff, sseen_ff, pseen_ff;
  logic        pe_ff, bcl_ff, port_irq_ff, coll_irq_ff;
  logic [1:0]  scl_sy_ff, sda_sy_ff;
  logic        sda_p_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff, pslverr_ff;
  logic        ev_start, ev_bfclr, ev_ack, ev_rx, ev_ackdone, ev_stop, ev_coll, ev_pe;

  // counter reload value, shared by every sequence
  function automatic logic [6:0] rld(input logic [6:0] r);
    return r;
  endfunction

  // ************************************
  // pin synchronisers and bus monitor
  // ************************************
  wire scl_s = scl_sy_ff[1];
  wire sda_s = sda_sy_ff[1];
  wire idle  = (st_ff == S_IDLE);
  wire tmo   = (cnt_ff == 7'h00);
  wire start_det = scl_s && sda_p_ff && !sda_s;
  wire stop_det  = scl_s && !sda_p_ff && sda_s;

  // two flops before anything looks at the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sy_ff <= 2'b11;
      sda_sy_ff <= 2'b11;
      sda_p_ff  <= 1'b1;
    end else if (ce) begin
      scl_sy_ff <= {scl_sy_ff[0], scl_i};
      sda_sy_ff <= {sda_sy_ff[0], sda_i};
      sda_p_ff  <= sda_sy_ff[1];
    end
  end

  // start/stop seen; disable clears both
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sseen_ff <= 1'b0;
      pseen_ff <= 1'b0;
    end else if (ce) begin
      if (!en_ff) begin
        sseen_ff <= 1'b0;
        pseen_ff <= 1'b0;
      end else if (start_det) begin
        sseen_ff <= 1'b1;
        pseen_ff <= 1'b0;
      end else if (stop_det) begin
        sseen_ff <= 1'b0;
        pseen_ff <= 1'b1;
      end
    end
  end

  // ************************************
  // apb slave
  // ************************************
  wire setup   = psel && !penable;
  wire acc     = psel && penable && pready_ff;
  wire wr_data = acc && pwrite && paddr == `ISM_A_DATA;
  wire rd_data = acc && !pwrite && paddr == `ISM_A_DATA;
  wire wr_ctrl = acc && pwrite && paddr == `ISM_A_CTRL;
  wire wr_stat = acc && pwrite && paddr == `ISM_A_STAT;
  wire wr_rate = acc && pwrite && paddr == `ISM_A_RATE;
  wire mapped  = paddr == `ISM_A_DATA || paddr == `ISM_A_CTRL ||
                 paddr == `ISM_A_STAT || paddr == `ISM_A_RATE;
  wire go_tx   = wr_data && idle && en_ff;
  wire any_seq = sen_ff || pen_ff || receive_sequence_enable_ff || ack_sequence_enable_ff;
  wire ctl_ok  = wr_ctrl && idle && en_ff && !any_seq;

  // read data captured in setup, pready registered from setup so every access completes with no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else if (ce) begin
      pready_ff  <= setup;
      pslverr_ff <= setup && !mapped;
      if (setup) begin
        unique case (paddr)
          `ISM_A_DATA: prdata_ff <= {24'h00_0000, buf_ff};
          `ISM_A_CTRL: prdata_ff <= {23'h00_0000, ie_ff, en_ff, ackst_ff, ack_value_bit_ff,
                                     ack_sequence_enable_ff, receive_sequence_enable_ff, pen_ff, 1'b0, sen_ff};
          `ISM_A_STAT: prdata_ff <= {24'h00_0000, idle, bcl_ff, pe_ff, pseen_ff,
                                     sseen_ff, ov_ff, write_collision_flag_ff, bf_ff};
          `ISM_A_RATE: prdata_ff <= {25'h000_0000, rate_ff};
          default:     prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ************************************
  // sequencer
  // ************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_op = op_ff;
    nxt_cnt = tmo ? cnt_ff : cnt_ff - 7'h01;
    nxt_bit = bit_ff;
    nxt_sr = sr_ff;
    nxt_hi = hi_ff;
    nxt_scl = scl_oe_ff;
    nxt_sda = sda_oe_ff;
    {ev_start, ev_bfclr, ev_ack, ev_rx, ev_ackdone, ev_stop, ev_coll, ev_pe} = 8'h00;
    unique case (st_ff)
      S_IDLE: begin
        nxt_hi = 1'b0;
        if (sen_ff) begin
          if (!scl_s || !sda_s) ev_coll = 1'b1;
          else begin
            nxt_cnt = rld(rate_ff);
            nxt_st = S_ST1;
          end
        end else if (pen_ff) begin
          nxt_sda = 1'b1;
          nxt_scl = 1'b1;
          nxt_st = S_SP1;
        end else if (receive_sequence_enable_ff) begin
          nxt_op = OP_RX;
          nxt_sda = 1'b0;
          nxt_scl = 1'b1;
          nxt_bit = `ISM_BIT_FIRST;
          nxt_cnt = rld(rate_ff);
          nxt_st = S_LOW;
        end else if (ack_sequence_enable_ff) begin
          nxt_op = OP_ACK;
          nxt_scl = 1'b1;
          nxt_sda = !ack_value_bit_ff;
          nxt_cnt = rld(rate_ff);
          nxt_st = S_LOW;
        end else if (go_tx) begin
          nxt_op = OP_TX;
          nxt_sr = pwdata[7:0];
          nxt_sda = !pwdata[7];
          nxt_scl = 1'b1;
          nxt_bit = `ISM_BIT_FIRST;
          nxt_cnt = rld(rate_ff);
          nxt_st = S_LOW;
        end
      end
      S_ST1: begin
        if (!sda_s) begin
          nxt_sda = 1'b1;
          nxt_cnt = rld(rate_ff);
          nxt_st = S_ST2;
        end else if (!scl_s) ev_coll = 1'b1;
        else if (tmo) begin
          nxt_sda = 1'b1;
          nxt_cnt = rld(rate_ff);
          nxt_st = S_ST2;
        end
      end
      S_ST2: begin
        // a low clock here is another master's start, not a collision
        if (tmo) begin
          nxt_scl = 1'b1;
          ev_start = 1'b1;
          ev_pe = 1'b1;
          nxt_st = S_IDLE;
        end
      end
      S_LOW: begin
        if (tmo) begin
          nxt_scl = 1'b0;
          nxt_hi = 1'b0;
          nxt_st = S_HIGH;
        end
      end
      S_HIGH: begin
        if (!hi_ff) begin
          nxt_cnt = cnt_ff;
          if (scl_s) begin
            nxt_hi = 1'b1;
            nxt_cnt = rld(rate_ff);
          end
        end else if (!sda_oe_ff && !sda_s && op_ff != OP_RX &&
                     !(op_ff == OP_TX && bit_ff == `ISM_ACK_BIT)) begin
          ev_coll = 1'b1;
        end else if (tmo) begin
          nxt_scl = 1'b1;
          nxt_cnt = rld(rate_ff);
          nxt_bit = bit_ff + 4'h1;
          nxt_st = S_LOW;
          unique case (op_ff)
            OP_TX: begin
              nxt_sr = {sr_ff[6:0], 1'b0};
              nxt_sda = !sr_ff[6];
              if (bit_ff == `ISM_LAST_BIT) begin
                nxt_sda = 1'b0;
                ev_bfclr = 1'b1;
              end else if (bit_ff == `ISM_ACK_BIT) begin
                ev_ack = 1'b1;
                ev_pe = 1'b1;
                nxt_st = S_IDLE;
              end
            end
            OP_RX: begin
              nxt_sr = {sr_ff[6:0], sda_s};
              if (bit_ff == `ISM_LAST_BIT) begin
                ev_rx = 1'b1;
                ev_pe = 1'b1;
                nxt_st = S_IDLE;
              end
            end
            default: begin
              ev_ackdone = 1'b1;
              nxt_st = S_IDLE;
            end
          endcase
        end
      end
      S_SP1: begin
        if (!sda_s) begin
          nxt_cnt = rld(rate_ff);
          nxt_hi = 1'b0;
          nxt_st = S_SP2;
        end
      end
      S_SP2: begin
        if (!hi_ff) begin
          if (tmo) begin
            nxt_scl = 1'b0;
            nxt_hi = 1'b1;
          end
        end else begin
          nxt_cnt = cnt_ff;
          if (scl_s) begin
            nxt_cnt = rld(rate_ff);
            nxt_hi = 1'b0;
            nxt_st = S_SP3;
          end
        end
      end
      S_SP3: begin
        if (!hi_ff) begin
          if (tmo) begin
            nxt_sda = 1'b0;
            nxt_hi = 1'b1;
          end
        end else if (!pseen_ff) nxt_cnt = rld(rate_ff);
        else if (tmo) begin
          ev_stop = 1'b1;
          ev_pe = 1'b1;
          nxt_st = S_IDLE;
        end
      end
      default: nxt_st = S_IDLE;
    endcase
    if (ev_coll || !en_ff) begin
      nxt_st = S_IDLE;
      nxt_scl = 1'b0;
      nxt_sda = 1'b0;
      nxt_hi = 1'b0;
    end
  end

  // sequencer registers; reset ends any transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= S_IDLE;
      op_ff <= OP_TX;
      cnt_ff <= 7'h00;
      bit_ff <= `ISM_BIT_FIRST;
      sr_ff <= 8'h00;
      hi_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else if (ce) begin
      st_ff <= nxt_st;
      op_ff <= nxt_op;
      cnt_ff <= nxt_cnt;
      bit_ff <= nxt_bit;
      sr_ff <= nxt_sr;
      hi_ff <= nxt_hi;
      scl_oe_ff <= nxt_scl;
      sda_oe_ff <= nxt_sda;
    end
  end

  // ************************************
  // software bits and flags
  // ************************************
  // sequence enables: taken only while idle, cleared by hardware
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {sen_ff, pen_ff, receive_sequence_enable_ff, ack_sequence_enable_ff} <= 4'h0;
      {en_ff, ie_ff, ack_value_bit_ff} <= 3'h0;
      rate_ff <= `ISM_RATE_RST;
    end else if (ce) begin
      if (wr_ctrl) begin
        en_ff <= pwdata[`ISM_C_EN];
        ie_ff <= pwdata[`ISM_C_IE];
        ack_value_bit_ff <= pwdata[`ISM_C_ACK_VALUE_BIT];
      end
      if (wr_rate) rate_ff <= pwdata[6:0];
      if (ctl_ok) begin
        sen_ff <= pwdata[`ISM_C_SEN];
        pen_ff <= pwdata[`ISM_C_PEN];
        receive_sequence_enable_ff <= pwdata[`ISM_C_RECEIVE_SEQUENCE_ENABLE];
        ack_sequence_enable_ff <= pwdata[`ISM_C_ACK_SEQUENCE_ENABLE];
      end else if (ev_coll || !en_ff) begin
        {sen_ff, pen_ff, receive_sequence_enable_ff, ack_sequence_enable_ff} <= 4'h0;
      end else begin
        if (ev_start) sen_ff <= 1'b0;
        if (ev_stop) pen_ff <= 1'b0;
        if (ev_rx) receive_sequence_enable_ff <= 1'b0;
        if (ev_ackdone) ack_sequence_enable_ff <= 1'b0;
      end
    end
  end

  // data buffer, buffer full, ack status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_ff <= 8'h00;
      bf_ff <= 1'b0;
      ackst_ff <= 1'b0;
    end else if (ce) begin
      if (go_tx) buf_ff <= pwdata[7:0];
      else if (ev_rx) buf_ff <= nxt_sr;
      // a load in the same cycle as a read keeps the flag set
      if (go_tx || ev_rx) bf_ff <= 1'b1;
      else if (ev_bfclr || rd_data || (ev_coll && op_ff == OP_TX)) bf_ff <= 1'b0;
      if (ev_ack) ackst_ff <= sda_s;
    end
  end

  // sticky event flags, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {write_collision_flag_ff, ov_ff, pe_ff, bcl_ff} <= 4'h0;
    end else if (ce) begin
      if (wr_data && !idle) write_collision_flag_ff <= 1'b1;
      else if (wr_stat && pwdata[`ISM_S_WRITE_COLLISION_FLAG]) write_collision_flag_ff <= 1'b0;
      if (ev_rx && bf_ff) ov_ff <= 1'b1;
      else if (wr_stat && pwdata[`ISM_S_OV]) ov_ff <= 1'b0;
      if (ev_pe || (stop_det && idle && en_ff)) pe_ff <= 1'b1;
      else if (wr_stat && pwdata[`ISM_S_PE]) pe_ff <= 1'b0;
      if (ev_coll) bcl_ff <= 1'b1;
      else if (wr_stat && pwdata[`ISM_S_BCL]) bcl_ff <= 1'b0;
    end
  end

  // interrupt requests follow the flags while enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_irq_ff <= 1'b0;
      coll_irq_ff <= 1'b0;
    end else if (ce) begin
      port_irq_ff <= pe_ff && ie_ff;
      coll_irq_ff <= bcl_ff && ie_ff;
    end
  end

  // ************************************
  // outputs
  // ************************************
  // open drain: the pins only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scl_oe_ff;
  assign sda_oe = sda_oe_ff;
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign port_irq = port_irq_ff;
  assign coll_irq = coll_irq_ff;

  // ************************************
  // assertions
  // ************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_stop_go;
    ce && idle && en_ff && !sen_ff && pen_ff;
  endsequence
  a_bf_tx_set: assert property (ce && go_tx |=> bf_ff && st_ff == S_LOW)
    else $error("buffer full not set by transmit write");
  a_write_collision_flag_busy: assert property (ce && wr_data && !idle |=> write_collision_flag_ff && !$past(go_tx))
    else $error("busy buffer write not flagged");
  a_ack_status: assert property (ce && ev_ack |=> ackst_ff == $past(sda_s) && idle)
    else $error("ack status wrong");
  a_receive_sequence_enable_busy: assert property (ce && wr_ctrl && !idle && !receive_sequence_enable_ff |=> !receive_sequence_enable_ff)
    else $error("receive enable taken while busy");
  a_rx_done: assert property (ce && ev_rx |=> idle && !receive_sequence_enable_ff && bf_ff && pe_ff && scl_oe_ff)
    else $error("receive completion wrong");
  a_ov_set: assert property (ce && ev_rx && bf_ff |=> ov_ff)
    else $error("overflow not flagged");
  a_hi_suspend: assert property (ce && st_ff == S_HIGH && !hi_ff && !scl_s && en_ff
                                 |=> cnt_ff == $past(cnt_ff))
    else $error("counter ran while clock held low");
  a_coll_idle: assert property (ce && ev_coll |=> idle && bcl_ff && !scl_oe_ff && !sda_oe_ff)
    else $error("collision did not release bus");
  a_stop_drive: assert property (s_stop_go |=> sda_oe_ff && st_ff == S_SP1)
    else $error("stop did not pull data low");
endmodule
`default_nettype wire

// ### dv/ism_slave_model.sv
`timescale 1ns/1ns
`default_nettype none
// ************************************
// slave device on the two-wire bus
// ************************************
module ism_slave_model (
  input  wire logic       pclk,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       rd,
  input  wire logic       ack_n,
  input  wire logic [7:0] rd_byte,
  input  wire logic [7:0] stretch,
  output logic            scl_pull,
  output logic            sda_pull,
  output logic [7:0]      rx_byte
);
  logic       scl_q = 1'b1;
  logic       sda_q = 1'b1;
  logic [7:0] sh = 8'h00;
  int         bit_n = -1;
  int         hold = 0;
  // read bits msb first, then release for the master's answer; write: answer in slot 8
  assign sda_pull = rd ? (bit_n >= 0 && bit_n < 8 && !rd_byte[7 - bit_n]) : (bit_n == 8 && !ack_n);
  // clock stretch after every fall, so the master must wait for the line
  assign scl_pull = (hold != 0);
  // bit framing; nba so the master's sync flops never race these pulls
  always @(posedge pclk) begin
    if (hold != 0) begin
      hold <= hold - 1;
    end
    if (scl && scl_q && sda_q != sda) begin
      bit_n <= -1;
    end else if (scl && !scl_q && bit_n < 8) begin
      sh <= {sh[6:0], sda};
      if (bit_n == 7) begin
        rx_byte <= {sh[6:0], sda};
      end
    end else if (!scl && scl_q) begin
      bit_n <= (bit_n == 8) ? 0 : bit_n + 1;
      hold <= int'(stretch);
    end
    scl_q <= scl;
    sda_q <= sda;
  end
endmodule
`default_nettype wire

// ### dv/test_ism_master.sv
`timescale 1ns/1ns
`default_nettype none
`include "ism_defines.svh"
module test_ism_master;
  import ism_pkg::*;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic        scl_o, scl_oe, sda_o, sda_oe, port_irq, coll_irq;
  logic        scl, sda, s_scl, s_sda, oth, s_rd, s_ackn, serr;
  logic [7:0]  paddr, s_rdb, s_str, s_rx;
  logic [31:0] pwdata, prdata, rdat, seed, oe_q;
  logic [7:0]  q[$];
  int          mismatches, comparisons, rate;
  int          hi_n = 0;
  int          hi_min = 9999;
  // ************************************
  // wiring
  // ************************************
  // open-drain lines with pull-ups
  assign scl = (scl_oe ? scl_o : 1'b1) & !s_scl;
  assign sda = (sda_oe ? sda_o : 1'b1) & !s_sda & !oth;
  ism_master ism_master_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_i(scl), .sda_i(sda),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe),
    .port_irq(port_irq), .coll_irq(coll_irq));
  ism_slave_model ism_slave_model_i (
    .pclk(pclk), .scl(scl), .sda(sda), .rd(s_rd), .ack_n(s_ackn), .rd_byte(s_rdb),
    .stretch(s_str), .scl_pull(s_scl), .sda_pull(s_sda), .rx_byte(s_rx));
  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // shortest high phase seen on the bus clock
  always @(posedge pclk) begin
    if (scl === 1'b1) begin
      hi_n++;
    end else begin
      if (hi_n > 0 && hi_n < hi_min) hi_min = hi_n;
      hi_n = 0;
    end
  end
  // ************************************
  // helpers
  // ************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkb(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask
  // request held until pready is sampled high; only the watchdog ends a wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // poll a bit, bounded so a stuck flag shows as a mismatch
  task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    do begin
      rd(a);
      n++;
    end while (rdat[b] !== v && n < 4000);
    chkb("poll", v, rdat[b]);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // watchdog: 30k cycles, several times what the run needs
  initial begin
    #300000;
    mismatches++;
    end_sim();
  end
  // ************************************
  // scenarios
  // ************************************
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {oth, s_rd, s_ackn, s_rdb, s_str} = '0;
    seed = 32'h2A;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`ISM_A_RATE);
    chk("rate_rst", {25'h0, `ISM_RATE_RST}, rdat);
    rd(8'h10);
    chkb("unmapped", 1'b1, serr);
    rate = 4 + int'(xs() & 32'h7);
    wr(`ISM_A_RATE, 32'(rate));
    wr(`ISM_A_CTRL, 32'h180);
    // data held low by another master before the start
    oth <= 1'b1;
    wr(`ISM_A_CTRL, 32'h181);
    wait_bit(`ISM_A_STAT, `ISM_S_BCL, 1'b1);
    rd(`ISM_A_CTRL);
    chkb("sen_clr", 1'b0, rdat[`ISM_C_SEN]);
    oth <= 1'b0;
    wait_bit(`ISM_A_STAT, `ISM_S_PE, 1'b1);
    wr(`ISM_A_STAT, 32'h66);
    // lost arbitration on the first data bit; start seen, bus taken anyway as seen flags are not checked
    wr(`ISM_A_CTRL, 32'h181);
    wait_bit(`ISM_A_STAT, `ISM_S_PE, 1'b1);
    wr(`ISM_A_STAT, 32'h20);
    oth <= 1'b1;
    wr(`ISM_A_DATA, 32'hFF);
    wait_bit(`ISM_A_STAT, `ISM_S_BCL, 1'b1);
    chkb("bf_coll", 1'b0, rdat[`ISM_S_BF]);
    chk("lines_rel", 32'h0, {30'h0, scl_oe, sda_oe});
    chkb("coll_irq", 1'b1, coll_irq);
    oth <= 1'b0;
    wait_bit(`ISM_A_STAT, `ISM_S_PE, 1'b1);
    wr(`ISM_A_STAT, 32'h66);
    repeat (3) @(posedge pclk);
    chkb("coll_irq_clr", 1'b0, coll_irq);
    // clean start, then an acked and a refused byte, the second one stretched
    wr(`ISM_A_CTRL, 32'h181);
    wait_bit(`ISM_A_STAT, `ISM_S_PE, 1'b1);
    chk("start_lines", 32'h0, {30'h0, scl, sda});
    chkb("port_irq", 1'b1, port_irq);
    for (int j = 0; j < 2; j++) begin
      wr(`ISM_A_STAT, 32'h22);
      s_ackn <= j[0];
      s_str <= j[0] ? 8'h1E : 8'h00;
      q.push_back(8'(xs()));
      wr(`ISM_A_DATA, {24'h0, q[0]});
      rd(`ISM_A_STAT);
      chkb("bf_set", 1'b1, rdat[`ISM_S_BF]);
      chkb("idle_busy", 1'b0, rdat[`ISM_S_IDLE]);
      wr(`ISM_A_DATA, {24'h0, ~q[0]});
      wait_bit(`ISM_A_STAT, `ISM_S_PE, 1'b1);
      chkb("write_collision_flag", 1'b1, rdat[`ISM_S_WRITE_COLLISION_FLAG]);
      chkb("bf_clr", 1'b0, rdat[`ISM_S_BF]);
      chk("tx_byte", {24'h0, q.pop_front()}, {24'h0, s_rx});
      rd(`ISM_A_CTRL);
      chkb("ack_status_bit", j[0], rdat[`ISM_C_ACKST]);
    end
    // three receptions; the second is left unread so the third overflows
    s_rd <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(`ISM_A_STAT, 32'h22);
      s_rdb <= 8'(xs());
      wr(`ISM_A_CTRL, 32'h188);
      wr(`ISM_A_DATA, 32'h0);
      if (i == 1) begin
        // frozen port: line drivers hold while the enable is low
        ce <= 1'b0;
        @(posedge pclk);
        oe_q = {30'h0, scl_oe, sda_oe};
        repeat (40) @(posedge pclk);
        chk("ce_hold", oe_q, {30'h0, scl_oe, sda_oe});
        ce <= 1'b1;
      end
      wait_bit(`ISM_A_STAT, `ISM_S_PE, 1'b1);
      chkb("rx_bf", 1'b1, rdat[`ISM_S_BF]);
      chkb("write_collision_flag_rx", 1'b1, rdat[`ISM_S_WRITE_COLLISION_FLAG]);
      chkb("ov", i == 2, rdat[`ISM_S_OV]);
      if (i == 0) begin
        rd(`ISM_A_DATA);
        chk("rx_byte", {24'h0, s_rdb}, rdat);
        rd(`ISM_A_STAT);
        chkb("rx_bf_clr", 1'b0, rdat[`ISM_S_BF]);
      end
      // acknowledge the first two, refuse the last; receive asked while busy
      wr(`ISM_A_CTRL, (i == 2) ? 32'h1B0 : 32'h190);
      wr(`ISM_A_CTRL, (i == 2) ? 32'h1A8 : 32'h188);
      wait_bit(`ISM_A_CTRL, `ISM_C_ACK_SEQUENCE_ENABLE, 1'b0);
      chkb("receive_sequence_enable_ign", 1'b0, rdat[`ISM_C_RECEIVE_SEQUENCE_ENABLE]);
      chkb("ack_scl_low", 1'b0, scl);
    end
    s_rd <= 1'b0;
    wr(`ISM_A_STAT, 32'h26);
    wr(`ISM_A_CTRL, 32'h184);
    wait_bit(`ISM_A_STAT, `ISM_S_PE, 1'b1);
    chkb("stop_seen", 1'b1, rdat[`ISM_S_STOP]);
    chkb("idle_stop", 1'b1, rdat[`ISM_S_IDLE]);
    chk("stop_lines", 32'h3, {30'h0, scl, sda});
    chkb("hi_min", 1'b1, hi_min >= rate);
    wr(`ISM_A_CTRL, 32'h0);
    rd(`ISM_A_STAT);
    chk("seen_clr", 32'h0, {30'h0, rdat[`ISM_S_STOP], rdat[`ISM_S_START]});
    // reset in mid-byte ends the transfer and frees both lines
    wr(`ISM_A_CTRL, 32'h180);
    wr(`ISM_A_CTRL, 32'h181);
    wait_bit(`ISM_A_CTRL, `ISM_C_SEN, 1'b0);
    wr(`ISM_A_DATA, 32'h55);
    repeat (20) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("rst_lines", 32'h0, {30'h0, scl_oe, sda_oe});
    rd(`ISM_A_CTRL);
    chkb("rst_en", 1'b0, rdat[`ISM_C_EN]);
    end_sim();
  end
endmodule
`default_nettype wire
